// ==== hw/tile_boot_loader_regs.svh ====
// offsets, fields, reset values and timing counts of the boot loader
`ifndef TILE_BOOT_LOADER_REGS_SVH
`define TILE_BOOT_LOADER_REGS_SVH
`define CLK_NS          10
`define CLK_HZ          100000000
`define RST_PHASE_NS    15000
`define RST_PHASE_CYC   ((`RST_PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define LINK_EN_NS      200
`define LINK_EN_CYC     (`LINK_EN_NS / `CLK_NS)
`define SPI_HZ          2500000
`define SPI_HALF_CYC    (`CLK_HZ / (2 * `SPI_HZ))
`define SPI_READ_CMD    8'h03
`define SPI_HDR_BITS    6'd32
`define IMG_SKIP_CRC    32'h0D15_AB1E
`define CRC_POLY        32'hEDB8_8320
`define CRC_PRESET      32'hFFFF_FFFF
`define NULL_CHAN       32'h0000_FF02
`define END_TOKEN       8'h01
`define BOOT_SEL_SPI    3'h1
`define BOOT_SEL_LINK   3'h2
`define BOOT_SEL_OTP    3'h3
`define SEC_NO_DEBUG    0
`define SEC_NO_SWITCH   1
`define SEC_SECURE_BOOT 5
`define SEC_REDUNDANT   7
`define SEC_SECTOR_LOCK 8
`define SEC_MASTER_LOCK 12
`define SEC_NO_DBG_OTP  13
`define SEC_NO_DBG_PIN  14
`define SEC_SW_MASK     32'h003F_8000
`define ID_OTP_ADDR     32'h0010_0200
`define ID_OTP_DATA     32'h0020_0100
`define ID_OTP_CTRL     32'h0010_0300
`define REG_CTRL        6'h00
`define REG_STATUS      6'h04
`define REG_SECURITY    6'h08
`define REG_OTP_ADDR    6'h0C
`define REG_OTP_DATA    6'h10
`define REG_OTP_CTRL    6'h14
`define REG_ID_ADDR     6'h18
`define REG_ID_DATA     6'h1C
`define REG_ID_CTRL     6'h20
`endif

// ==== hw/tile_boot_loader_pkg.sv ====
// types shared by the boot loader and its bench
package tile_boot_loader_pkg;
	// boot sequencer states, one-hot
	typedef enum logic [8:0] {
		S_RESET = 9'h001,
		S_SELECT = 9'h002,
		S_SPI = 9'h004,
		S_LINKW = 9'h008,
		S_LINK = 9'h010,
		S_OTP = 9'h020,
		S_ACK = 9'h040,
		S_RUN = 9'h080,
		S_FAIL = 9'h100
	} boot_state_t;
	// image field being parsed
	typedef enum logic [2:0] {
		P_ACK, P_LEN, P_PROG, P_CRC, P_END
	} phase_t;
	// ram write port
	typedef struct packed {
		logic        we;
		logic [13:0] addr;
		logic [31:0] data;
	} ram_wr_t;
	// fixed spi boot pins
	typedef struct packed {
		logic oe_n;
		logic sclk;
		logic sel_n;
		logic mosi;
	} spi_pins_t;
	// outgoing link token
	typedef struct packed {
		logic       valid;
		logic       ctl;
		logic [7:0] data;
	} link_tok_t;
endpackage : tile_boot_loader_pkg

// ==== hw/tile_boot_loader.sv ====
// boot sequencer with spi, link and otp image loaders and an axi4-lite slave
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "tile_boot_loader_regs.svh"
module tile_boot_loader (
	input  wire logic                             mclk,
	input  wire logic                             rst_n,
	input  wire logic [4:0]                       strap_pins,
	input  wire logic [31:0]                      otp_sec_word,
	output logic      [1:0]                       clock_mode,
	output logic                                  gpio_pull_en,
	output logic                                  gpio_oe_n,
	input  wire logic                             boot_spi_miso_pin,
	output tile_boot_loader_pkg::spi_pins_t       spi_pins,
	output logic                                  link_oe_n,
	output logic                                  link_pulldown_en,
	output logic                                  link_out_wire_a,
	output logic                                  link_out_wire_b,
	input  wire logic                             link_in_wire_a,
	input  wire logic                             link_in_wire_b,
	input  wire logic                             link_rx_valid,
	input  wire logic                             link_rx_ctl,
	input  wire logic [7:0]                       link_rx_data,
	output tile_boot_loader_pkg::link_tok_t       link_tx,
	input  wire logic                             link_tx_ready,
	output logic                                  otp_rd_en,
	output logic      [10:0]                      otp_rd_row,
	input  wire logic [31:0]                      otp_rd_data,
	output logic                                  otp_prog,
	output logic      [15:0]                      otp_prog_addr,
	output logic      [31:0]                      otp_prog_data,
	output logic      [15:0]                      otp_prog_ctrl,
	output tile_boot_loader_pkg::ram_wr_t         ram_wr,
	output logic                                  core_run,
	output logic      [31:0]                      sec_config,
	input  wire logic [5:0]                       awaddr,
	input  wire logic                             awvalid,
	output logic                                  awready,
	input  wire logic [31:0]                      wdata,
	input  wire logic [3:0]                       wstrb,
	input  wire logic                             wvalid,
	output logic                                  wready,
	output logic      [1:0]                       bresp,
	output logic                                  bvalid,
	input  wire logic                             bready,
	input  wire logic [5:0]                       araddr,
	input  wire logic                             arvalid,
	output logic                                  arready,
	output logic      [31:0]                      rdata,
	output logic      [1:0]                       rresp,
	output logic                                  rvalid,
	input  wire logic                             rready
);
	// whole block state in one record
	typedef struct packed {
		tile_boot_loader_pkg::boot_state_t state;
		tile_boot_loader_pkg::phase_t      phase;
		logic [10:0] cnt;      // reset and link timers
		logic [1:0]  clkmode;  // captured clock straps
		logic        pull_en;
		logic        oe_n;
		logic [31:0] sec;      // security config
		logic [31:0] crc;
		logic [31:0] word;     // byte assembler
		logic [1:0]  idx;
		logic [31:0] left;     // words still to load
		logic [31:0] ack;      // link reply channel
		logic        ok;
		tile_boot_loader_pkg::ram_wr_t ram;
		logic [13:0] ptr;
		logic        run;
		logic        fail;
		tile_boot_loader_pkg::spi_pins_t spi;
		logic [4:0]  div;
		logic [5:0]  bitn;
		logic [7:0]  rxsr;
		logic        link_en;
		logic        chan0;    // channel end 0 held
		tile_boot_loader_pkg::link_tok_t tx;
		logic        rd_en;
		logic        rd_pend;
		logic [10:0] row;
		logic [31:0] otw;      // otp word being unpacked
		logic [2:0]  otn;
		logic        prog;
		logic        refused;
		logic [15:0] paddr;
		logic [31:0] pdata;
		logic [15:0] pctrl;
		logic        awr;
		logic        bv;
		logic [1:0]  br;
		logic        arr;
		logic        rv;
		logic [1:0]  rr;
		logic [31:0] rd;
	} st_t;

	st_t st_q, st_d;

	// one crc-32 byte step, reflected form
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] x;
		x = c ^ {24'h0000_00, b};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction : crc_step

	// byte-enable merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
		end
		return r;
	endfunction : merge

	logic        got;    // one image byte this cycle
	logic [7:0]  b;
	logic [31:0] wn;     // word with the new byte on top
	logic        rise;   // spi clock about to rise
	logic        fall;
	logic        wr_hit;
	logic        lock;
	logic [7:0]  cmd;    // read command, held in a variable so single bits can be picked

	// next-state logic
	always_comb begin
		st_d = st_q;
		cmd = `SPI_READ_CMD;
		got = 1'b0;
		b = 8'h00;
		st_d.ram.we = 1'b0;
		st_d.prog = 1'b0;
		st_d.rd_en = 1'b0;
		rise = 1'b0;
		fall = 1'b0;
		// spi engine runs only while booting from flash
		if (st_q.state == tile_boot_loader_pkg::S_SPI) begin
			if (st_q.div == 5'(`SPI_HALF_CYC - 1)) begin
				st_d.div = 5'h00;
				rise = !st_q.spi.sclk;
				fall = st_q.spi.sclk;
				st_d.spi.sclk = !st_q.spi.sclk;
			end else begin
				st_d.div = st_q.div + 5'h01;
			end
			if (rise) begin
				// mode 0: sample on rising edge, lsb first
				st_d.rxsr = {boot_spi_miso_pin, st_q.rxsr[7:1]};
				// count on to the end of one data byte past the header, then hold
				if (st_q.bitn != 6'(`SPI_HDR_BITS + 6'd8)) st_d.bitn = st_q.bitn + 6'h01;
			end
			if (fall) begin
				// header is command then three zero address bytes
				st_d.spi.mosi = (st_q.bitn < 6'd8) ? cmd[st_q.bitn[2:0]] : 1'b0;
				// a byte is whole only after eight rises beyond the header
				if (st_q.bitn == 6'(`SPI_HDR_BITS + 6'd8)) begin
					st_d.bitn = `SPI_HDR_BITS;
					got = 1'b1;
					b = st_q.rxsr;
				end
			end
		end
		// link data tokens
		if (st_q.state == tile_boot_loader_pkg::S_LINK && link_rx_valid && !link_rx_ctl
			&& st_q.phase != tile_boot_loader_pkg::P_END) begin
			got = 1'b1;
			b = link_rx_data;
		end
		// otp words unpacked low byte first
		if (st_q.state == tile_boot_loader_pkg::S_OTP) begin
			st_d.rd_pend = st_q.rd_en;
			if (st_q.rd_pend) begin
				st_d.otw = otp_rd_data;
				st_d.otn = 3'h4;
			end else if (st_q.otn != 3'h0) begin
				got = 1'b1;
				b = st_q.otw[7:0];
				st_d.otw = {8'h00, st_q.otw[31:8]};
				st_d.otn = st_q.otn - 3'h1;
			end else if (!st_q.rd_en) begin
				st_d.rd_en = 1'b1;
				st_d.row = st_q.row + 11'h001;
			end
		end
		wn = {b, st_q.word[31:8]};
		// image parser shared by all sources
		if (got) begin
			st_d.word = wn;
			st_d.idx = st_q.idx + 2'h1;
			if (st_q.phase == tile_boot_loader_pkg::P_LEN ||
				st_q.phase == tile_boot_loader_pkg::P_PROG) begin
				st_d.crc = crc_step(st_q.crc, b);
			end
			if (st_q.idx == 2'h3) begin
				case (st_q.phase)
					tile_boot_loader_pkg::P_ACK: begin
						st_d.ack = wn;
						st_d.phase = tile_boot_loader_pkg::P_LEN;
					end
					tile_boot_loader_pkg::P_LEN: begin
						st_d.left = wn;
						st_d.phase = (wn == 32'h0000_0000) ? tile_boot_loader_pkg::P_CRC
							: tile_boot_loader_pkg::P_PROG;
					end
					tile_boot_loader_pkg::P_PROG: begin
						st_d.ram.we = 1'b1;
						st_d.ram.addr = st_q.ptr;
						st_d.ram.data = wn;
						st_d.ptr = st_q.ptr + 14'h0001;
						st_d.left = st_q.left - 32'h0000_0001;
						if (st_q.left == 32'h0000_0001) st_d.phase = tile_boot_loader_pkg::P_CRC;
					end
					default: begin
						// skip value or inverted residue both pass
						st_d.ok = (wn == `IMG_SKIP_CRC) || (wn == ~st_q.crc);
						if (st_q.state == tile_boot_loader_pkg::S_LINK) begin
							st_d.phase = tile_boot_loader_pkg::P_END;
						end else if ((wn == `IMG_SKIP_CRC) || (wn == ~st_q.crc)) begin
							st_d.state = tile_boot_loader_pkg::S_RUN;
						end else begin
							st_d.state = tile_boot_loader_pkg::S_FAIL;
						end
					end
				endcase
			end
		end
		// sequencer
		case (st_q.state)
			tile_boot_loader_pkg::S_RESET: begin
				st_d.cnt = st_q.cnt + 11'h001;
				if (st_q.cnt == 11'(`RST_PHASE_CYC - 1)) begin
					st_d.pull_en = 1'b1;
					st_d.clkmode = strap_pins[1:0];
					st_d.sec = otp_sec_word;
					st_d.state = tile_boot_loader_pkg::S_SELECT;
				end
			end
			tile_boot_loader_pkg::S_SELECT: begin
				st_d.cnt = 11'h000;
				st_d.crc = `CRC_PRESET;
				st_d.ptr = 14'h0000;
				st_d.idx = 2'h0;
				st_d.phase = tile_boot_loader_pkg::P_LEN;
				if (st_q.sec[`SEC_SECURE_BOOT]) begin
					st_d.state = tile_boot_loader_pkg::S_OTP;
				end else begin
					case (strap_pins[4:2])
						`BOOT_SEL_SPI: st_d.state = tile_boot_loader_pkg::S_SPI;
						`BOOT_SEL_LINK: st_d.state = tile_boot_loader_pkg::S_LINKW;
						`BOOT_SEL_OTP: st_d.state = tile_boot_loader_pkg::S_OTP;
						default: st_d.state = tile_boot_loader_pkg::S_FAIL;
					endcase
				end
				// otp image starts at row zero
				st_d.row = 11'h7FF;
				st_d.otn = 3'h0;
				// spi pins are hard wired, no remap
				st_d.spi = '{oe_n: 1'b0, sclk: 1'b0, sel_n: 1'b0,
					mosi: cmd[0]};
				st_d.bitn = 6'h00;
				st_d.div = 5'h00;
				st_d.oe_n = 1'b0;
			end
			tile_boot_loader_pkg::S_LINKW: begin
				st_d.cnt = st_q.cnt + 11'h001;
				if (st_q.cnt == 11'(`LINK_EN_CYC - 1)) begin
					st_d.link_en = 1'b1;
					st_d.chan0 = 1'b1;
					st_d.phase = tile_boot_loader_pkg::P_ACK;
					st_d.state = tile_boot_loader_pkg::S_LINK;
				end
			end
			tile_boot_loader_pkg::S_LINK: begin
				// end token closes the image
				if (st_q.phase == tile_boot_loader_pkg::P_END && link_rx_valid && link_rx_ctl
					&& link_rx_data == `END_TOKEN) begin
					if (!st_q.ok) st_d.state = tile_boot_loader_pkg::S_FAIL;
					else if (st_q.ack == `NULL_CHAN) st_d.state = tile_boot_loader_pkg::S_RUN;
					else begin
						st_d.tx = '{valid: 1'b1, ctl: 1'b1, data: `END_TOKEN};
						st_d.state = tile_boot_loader_pkg::S_ACK;
					end
				end
			end
			tile_boot_loader_pkg::S_ACK: begin
				if (link_tx_ready) begin
					st_d.tx.valid = 1'b0;
					st_d.state = tile_boot_loader_pkg::S_RUN;
				end
			end
			tile_boot_loader_pkg::S_RUN: begin
				st_d.run = 1'b1;
				st_d.chan0 = 1'b0;
			end
			tile_boot_loader_pkg::S_FAIL: begin
				st_d.fail = 1'b1;
				st_d.chan0 = 1'b0;
			end
			default: begin
			end
		endcase
		// flash deselected once loading ends
		if (st_d.state != tile_boot_loader_pkg::S_SPI &&
			st_d.state != tile_boot_loader_pkg::S_SELECT) begin
			st_d.spi.sel_n = 1'b1;
			st_d.spi.sclk = 1'b0;
		end
		// axi write: take address and data together
		st_d.awr = awvalid && wvalid && !st_q.awr && !st_q.bv;
		wr_hit = st_q.awr && awvalid && wvalid;
		lock = st_q.sec[`SEC_MASTER_LOCK] ||
			st_q.sec[`SEC_SECTOR_LOCK + st_q.paddr[10:9]];
		if (wr_hit) begin
			st_d.bv = 1'b1;
			st_d.br = 2'b00;
			case (awaddr)
				`REG_CTRL: begin
					// software restart of the sequencer
					if (wstrb[0] && wdata[0]) st_d.state = tile_boot_loader_pkg::S_SELECT;
				end
				`REG_SECURITY: begin
					// otp bits only ever set, never clear
					if (!st_q.sec[`SEC_MASTER_LOCK])
						st_d.sec = st_q.sec | (merge(32'h0000_0000, wdata, wstrb) & `SEC_SW_MASK);
				end
				`REG_OTP_ADDR: st_d.paddr = 16'(merge({16'h0000, st_q.paddr}, wdata, wstrb));
				`REG_OTP_DATA: st_d.pdata = merge(st_q.pdata, wdata, wstrb);
				`REG_OTP_CTRL: begin
					st_d.pctrl = 16'(merge({16'h0000, st_q.pctrl}, wdata, wstrb));
					if (wstrb[0] && wdata[0]) begin
						st_d.prog = !lock;
						st_d.refused = lock;
					end
				end
				default: st_d.br = 2'b10;
			endcase
		end
		if (st_q.bv && bready) st_d.bv = 1'b0;
		// axi read
		st_d.arr = arvalid && !st_q.arr && !st_q.rv;
		if (st_q.arr && arvalid) begin
			st_d.rv = 1'b1;
			st_d.rr = 2'b00;
			case (araddr)
				`REG_CTRL: st_d.rd = 32'h0000_0000;
				`REG_STATUS: st_d.rd = {16'h0000, st_q.refused, st_q.ok, st_q.fail,
					st_q.run, link_in_wire_b, link_in_wire_a, 1'b0, st_q.state};
				`REG_SECURITY: st_d.rd = st_q.sec;
				`REG_OTP_ADDR: st_d.rd = {16'h0000, st_q.paddr};
				`REG_OTP_DATA: st_d.rd = st_q.pdata;
				`REG_OTP_CTRL: st_d.rd = {16'h0000, st_q.pctrl};
				`REG_ID_ADDR: st_d.rd = `ID_OTP_ADDR;
				`REG_ID_DATA: st_d.rd = `ID_OTP_DATA;
				`REG_ID_CTRL: st_d.rd = `ID_OTP_CTRL;
				default: begin
					st_d.rd = 32'h0000_0000;
					st_d.rr = 2'b10;
				end
			endcase
		end
		if (st_q.rv && rready) st_d.rv = 1'b0;
	end

	// register the whole state
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_q <= '0;
			st_q.state <= tile_boot_loader_pkg::S_RESET;
			st_q.oe_n <= 1'b1;
			st_q.spi <= '{oe_n: 1'b1, sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
			st_q.crc <= `CRC_PRESET;
		end else begin
			st_q <= st_d;
		end
	end

	// outputs from the record, the link out wires tied low
	assign clock_mode = st_q.clkmode;
	assign gpio_pull_en = st_q.pull_en;
	assign gpio_oe_n = st_q.oe_n;
	assign spi_pins = st_q.spi;
	assign link_oe_n = !st_q.link_en;
	assign link_pulldown_en = !st_q.link_en;
	assign link_out_wire_a = 1'b0;
	assign link_out_wire_b = 1'b0;
	assign link_tx = st_q.tx;
	assign otp_rd_en = st_q.rd_en;
	assign otp_rd_row = st_q.row;
	assign otp_prog = st_q.prog;
	assign otp_prog_addr = st_q.paddr;
	assign otp_prog_data = st_q.pdata;
	assign otp_prog_ctrl = st_q.pctrl;
	assign ram_wr = st_q.ram;
	assign core_run = st_q.run;
	// bits 0,1,7,13,14 are decoded by their consumers
	assign sec_config = st_q.sec;
	assign awready = st_q.awr;
	assign wready = st_q.awr;
	assign bvalid = st_q.bv;
	assign bresp = st_q.br;
	assign arready = st_q.arr;
	assign rvalid = st_q.rv;
	assign rresp = st_q.rr;
	assign rdata = st_q.rd;

	// checks
	sequence s_release;
		!$past(rst_n) && rst_n;
	endsequence
	property p_float_in_reset;
		@(posedge mclk) !rst_n |=> gpio_oe_n && spi_pins.oe_n && !gpio_pull_en;
	endproperty
	a_float_in_reset: assert property (p_float_in_reset) else $error("pins driven in reset");
	property p_phase_wait;
		@(posedge mclk) disable iff (!rst_n) s_release |-> !gpio_pull_en [*8];
	endproperty
	a_phase_wait: assert property (p_phase_wait) else $error("pulls on too early");
	property p_strap_spi;
		@(posedge mclk) disable iff (!rst_n) st_q.state == tile_boot_loader_pkg::S_SELECT &&
			!st_q.sec[5] && strap_pins[4:2] == 3'h1 |=> st_q.state == tile_boot_loader_pkg::S_SPI;
	endproperty
	a_strap_spi: assert property (p_strap_spi) else $error("strap source ignored");
	property p_secure;
		@(posedge mclk) disable iff (!rst_n) st_q.state == tile_boot_loader_pkg::S_SELECT &&
			st_q.sec[5] |=> st_q.state == tile_boot_loader_pkg::S_OTP;
	endproperty
	a_secure: assert property (p_secure) else $error("secure boot not from otp");
	property p_no_run_bad;
		@(posedge mclk) disable iff (!rst_n) st_q.fail |-> !core_run;
	endproperty
	a_no_run_bad: assert property (p_no_run_bad) else $error("failed image started");
	property p_sclk_half;
		@(posedge mclk) disable iff (!rst_n) $rose(spi_pins.sclk) |=> spi_pins.sclk [*8];
	endproperty
	a_sclk_half: assert property (p_sclk_half) else $error("spi clock too fast");
	property p_link_low;
		@(posedge mclk) disable iff (!rst_n) !link_oe_n |-> !link_out_wire_a && !link_out_wire_b;
	endproperty
	a_link_low: assert property (p_link_low) else $error("link wires not low");
	property p_prog_lock;
		@(posedge mclk) disable iff (!rst_n) otp_prog |-> !$past(st_q.sec[12]);
	endproperty
	a_prog_lock: assert property (p_prog_lock) else $error("locked otp programmed");
endmodule : tile_boot_loader

// ==== tb/spi_boot_flash.sv ====
// spi flash model: mode 0, lsb first, serves the boot image after the header
`timescale 1ns/1ns
module spi_boot_flash (
	input  wire logic sclk,
	input  wire logic sel_n,
	input  wire logic mosi,
	output logic      miso
);
	logic [7:0]  mem [0:15];  // image bytes, filled by the bench
	logic [31:0] hdr;         // command and address as shifted in
	int          rises = 0;   // sclk rises in this frame
	logic        q = 1'b0;    // bit on the wire
	// header bits are taken on the rising edge
	always @(posedge sclk or posedge sel_n) begin
		if (sel_n)
			rises <= 0;
		else begin
			if (rises < 32)
				hdr <= {mosi, hdr[31:1]};
			rises <= rises + 1;
		end
	end
	// data changes on the falling edge, byte order as stored
	always @(negedge sclk)
		if (!sel_n && rises >= 32)
			q <= mem[(rises - 32) / 8][(rises - 32) % 8];
	// deselected line shows the inverse so stale data never passes
	assign miso = sel_n ? ~q : q;
endmodule : spi_boot_flash

// ==== tb/tile_boot_loader_bench.sv ====
// bench for the boot loader: registers, spi, otp and link boot
`timescale 1ns/1ns
`include "tile_boot_loader_regs.svh"
module tile_boot_loader_bench;
	logic mclk = 0, rst_n = 0, link_in_wire_a = 0, link_in_wire_b = 0;
	logic link_rx_valid = 0, link_rx_ctl = 0, link_tx_ready = 0, awvalid = 0, wvalid = 0;
	logic bready = 0, arvalid = 0, rready = 0, gpio_pull_en, gpio_oe_n, boot_spi_miso_pin;
	logic link_oe_n, link_pulldown_en, link_out_wire_a, link_out_wire_b, otp_rd_en;
	logic otp_prog, core_run, awready, wready, bvalid, arready, rvalid;
	logic [1:0]  clock_mode, bresp, rresp;
	logic [3:0]  wstrb = 4'hF;
	logic [4:0]  strap_pins = 5'h00;
	logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
	logic [7:0]  link_rx_data = 8'h00;
	logic [7:0]  img [0:11];
	logic [10:0] otp_rd_row, first_row;
	logic [15:0] otp_prog_addr, otp_prog_ctrl;
	logic [31:0] otp_sec_word = 32'h0000_0000, wdata = 32'h0000_0000, otp_rd_data;
	logic [31:0] otp_prog_data, sec_config, rdata, wr_data;
	logic [13:0] wr_addr;
	tile_boot_loader_pkg::spi_pins_t spi_pins;
	tile_boot_loader_pkg::link_tok_t link_tx;
	tile_boot_loader_pkg::ram_wr_t   ram_wr;
	logic sclk_hi, sclk_lo, tx_valid;  // struct members as plain variables for bounded waits
	int failures = 0, checks = 0, wr_cnt = 0, rd_cnt = 0, prog_cnt = 0;
	tile_boot_loader dut (.*);
	spi_boot_flash flash (.sclk(spi_pins.sclk), .sel_n(spi_pins.sel_n),
		.mosi(spi_pins.mosi), .miso(boot_spi_miso_pin));
	always #5 mclk = ~mclk;
	assign sclk_hi  = spi_pins.sclk;
	assign sclk_lo  = !spi_pins.sclk;
	assign tx_valid = link_tx.valid;
	// otp rows hold the image words, low byte in bits 7:0
	assign otp_rd_data = {img[4 * otp_rd_row + 3], img[4 * otp_rd_row + 2],
		img[4 * otp_rd_row + 1], img[4 * otp_rd_row]};
	// watch ram writes, otp reads and programming pulses
	always @(posedge mclk) begin
		if (ram_wr.we) begin
			wr_addr <= ram_wr.addr;
			wr_data <= ram_wr.data;
			wr_cnt  <= wr_cnt + 1;
		end
		if (otp_rd_en && rd_cnt == 0)
			first_row <= otp_rd_row;
		if (otp_rd_en)
			rd_cnt <= rd_cnt + 1;
		if (otp_prog)
			prog_cnt <= prog_cnt + 1;
	end
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// bounded wait for a level seen at a rising edge
	task automatic until_high(ref logic s, input int lim);
		int n;
		n = 0;
		do @(posedge mclk); while (s !== 1'b1 && ++n < lim);
		if (n >= lim) begin
			failures++;
			tally_and_finish;
		end
	endtask : until_high
	task automatic axi_wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1;
		wvalid  <= 1;
		until_high(awready, 40);
		awvalid <= 0;
		wvalid  <= 0;
		bready  <= 1;
		until_high(bvalid, 40);
		r = bresp;
		bready <= 0;
	endtask : axi_wr
	task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge mclk);
		araddr  <= a;
		arvalid <= 1;
		until_high(arready, 40);
		arvalid <= 0;
		rready  <= 1;
		until_high(rvalid, 40);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask : axi_rd
	// reflected crc over the first n image bytes
	function automatic logic [31:0] crc32(input int n);
		logic [31:0] c;
		c = `CRC_PRESET;
		for (int i = 0; i < n; i++) begin
			c = c ^ img[i];
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction : crc32
	// one-word image; the crc can be spoiled or replaced by the skip value
	task automatic load_image(input logic [31:0] w, input logic [31:0] bad, input logic skip);
		{img[3], img[2], img[1], img[0]} = 32'h0000_0001;
		{img[7], img[6], img[5], img[4]} = w;
		{img[11], img[10], img[9], img[8]} = skip ? `IMG_SKIP_CRC : crc32(8) ^ bad;
		for (int i = 0; i < 12; i++)
			flash.mem[i] = img[i];
	endtask : load_image
	// reset, then step through the reset phase
	task automatic boot(input logic [4:0] straps, input logic [31:0] sec);
		@(posedge mclk);
		rst_n        <= 0;
		strap_pins   <= straps;
		otp_sec_word <= sec;
		wr_cnt   = 0;
		rd_cnt   = 0;
		prog_cnt = 0;
		repeat (20) @(posedge mclk);
		chk("gpio oe_n in reset", 1, gpio_oe_n);
		rst_n <= 1;
		repeat (1400) @(posedge mclk);
		chk("pulls early", 0, gpio_pull_en);
		repeat (110) @(posedge mclk);
		chk("pulls", 1, gpio_pull_en);
		chk("clock mode", straps[1:0], clock_mode);
	endtask : boot
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		logic [31:0] ids [3];
		ids = '{`ID_OTP_ADDR, `ID_OTP_DATA, `ID_OTP_CTRL};
		boot(5'h00, 32'h0000_0103);
		axi_wr(`REG_SECURITY, 32'hFFFF_FFFF, r);
		chk("security", 32'h003F_8103, sec_config);
		for (int i = 0; i < 3; i++) begin
			axi_rd(`REG_ID_ADDR + 6'(4 * i), d, r);
			chk("port id", ids[i], d);
		end
		axi_rd(6'h3C, d, r);
		chk("unmapped read", 2'b10, r);
		axi_wr(`REG_OTP_DATA, 32'hC0DE_0001, r);
		// sector 1 is open, sector 0 is locked
		for (int s = 0; s < 2; s++) begin
			axi_wr(`REG_OTP_ADDR, s ? 32'h0000_0000 : 32'h0000_0200, r);
			axi_wr(`REG_OTP_CTRL, 32'h0000_0001, r);
			repeat (2) @(posedge mclk);
			chk("program pulses", 1, prog_cnt);
		end
		chk("program data", 32'hC0DE_0001, otp_prog_data);
		chk("program addr", 0, otp_prog_addr);
		chk("program ctrl", 1, otp_prog_ctrl);
		axi_rd(`REG_STATUS, d, r);
		chk("status", 32'h0000_A100, d);
		$display("test regs done");
	endtask : t_regs
	task automatic t_spi;
		time t0;
		load_image(32'hA5C3_0F96, 32'h0000_0000, 0);
		boot({`BOOT_SEL_SPI, 2'b01}, 32'h0000_0000);
		chk("spi pins on", 0, {spi_pins.oe_n, spi_pins.sel_n});
		until_high(sclk_hi, 100);
		t0 = $time;
		until_high(sclk_lo, 100);
		chk("sclk period ns", 400, 32'(2 * ($time - t0)));
		until_high(core_run, 6000);
		chk("spi header", 32'h0000_0003, flash.hdr);
		chk("ram address", 0, wr_addr);
		chk("ram word", 32'hA5C3_0F96, wr_data);
		chk("ram writes", 1, wr_cnt);
		$display("test spi done");
	endtask : t_spi
	task automatic t_otp;
		logic [1:0] r;
		// good crc, spoiled crc, skip value; straps say spi
		for (int k = 0; k < 3; k++) begin
			load_image(32'h1357_9BDF, k == 1, k == 2);
			boot({`BOOT_SEL_SPI, 2'b10}, 32'h0000_0020);
			repeat (300) @(posedge mclk);
			chk("otp run", k != 1, core_run);
			chk("otp first row", 0, first_row);
			chk("spi idle", 1, spi_pins.sel_n);
			chk("security load", 32'h0000_0020, sec_config);
			if (k == 2) begin
				// software restart loads the three otp rows once more
				axi_wr(`REG_CTRL, 32'h0000_0001, r);
				chk("write resp", 0, r);
				repeat (100) @(posedge mclk);
				chk("restart reads", 6, rd_cnt);
			end
		end
		$display("test otp done");
	endtask : t_otp
	task automatic t_link;
		logic [31:0] ack;
		// ack word 5 needs a reply; the null channel needs none
		for (int j = 0; j < 2; j++) begin
			ack = j ? `NULL_CHAN : 32'h0000_0005;
			load_image(32'h2468_ACE0 ^ j, 32'h0000_0000, 0);
			boot({`BOOT_SEL_LINK, 2'b11}, 32'h0000_0000);
			chk("link off early", 1, link_oe_n);
			repeat (20) @(posedge mclk);
			chk("link on", 0, {link_oe_n, link_pulldown_en});
			chk("link wires", 0, {link_out_wire_a, link_out_wire_b});
			for (int i = 0; i < 17; i++) begin
				link_rx_valid <= 1;
				link_rx_ctl   <= i == 16;
				link_rx_data  <= i < 4 ? ack[8 * i +: 8] : i < 16 ? img[i - 4] : `END_TOKEN;
				@(posedge mclk);
			end
			link_rx_valid <= 0;
			if (j == 0) begin
				until_high(tx_valid, 50);
				chk("end reply", {2'b11, `END_TOKEN}, link_tx);
				chk("run waits", 0, core_run);
				link_tx_ready <= 1;
			end
			until_high(core_run, 50);
			link_tx_ready <= 0;
			chk("no reply left", 0, link_tx.valid);
			chk("link word", 32'h2468_ACE0 ^ j, wr_data);
		end
		$display("test link done");
	endtask : t_link
	initial begin
		t_regs;
		t_spi;
		t_otp;
		t_link;
		tally_and_finish;
	end
endmodule : tile_boot_loader_bench
